/* hdl/scl_pkg.sv */
`default_nettype none
package scl_pkg;
  // register byte addresses on the wishbone slave
  localparam logic [7:0] CMD_ADDR      = 8'h00;
  localparam logic [7:0] SETUP_ADDR    = 8'h04;
  localparam logic [7:0] EE_ADDR_ADDR  = 8'h08;
  localparam logic [7:0] EE_DATA_ADDR  = 8'h0c;
  localparam logic [7:0] STATUS_ADDR   = 8'h10;
  // command byte fields
  localparam int CH_LSB  = 0;
  localparam int CH_MSB  = 4;
  localparam int RNG_LSB = 5;
  localparam int RNG_MSB = 7;
  // setup byte fields
  localparam int SETUP_SE_BIT   = 0;
  localparam int SETUP_BUSY_BIT = 7;
  localparam logic [7:0] SETUP_DIFF_VAL = 8'h00;
  localparam logic [7:0] SETUP_SE_VAL   = 8'h11;
  // status word fields
  localparam int ST_OFS_LSB    = 0;
  localparam int ST_GAIN_LSB   = 8;
  localparam int ST_LOAD_BIT   = 16;
  localparam int ST_STORE_BIT  = 17;
  // eeprom map: gain bytes sit 100h above offset bytes
  localparam int EE_AW = 9;
  localparam logic EE_OFS_REGION  = 1'b0;
  localparam logic EE_GAIN_REGION = 1'b1;
  localparam logic [7:0] EE_MID_SCALE = 8'h80;
  // reset values
  localparam logic [7:0] CMD_RST   = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] POT_RST   = 8'h80;
  // example channel code for the seventeenth single-ended input
  localparam logic [4:0] SINGLE_ENDED_INPUT_SIXTEEN = 5'h10;
  // range codes
  typedef enum logic [2:0] {
    RNG_10V    = 3'h0,
    RNG_5V     = 3'h1,
    RNG_2V5    = 3'h2,
    RNG_100MV  = 3'h3,
    RNG_50MV   = 3'h4,
    RNG_25MV   = 3'h5
  } scl_range_t;
  // store timing
  localparam int CLK_MHZ           = 50;
  localparam int STORE_TIME_US     = 1000;
  localparam int STORE_CYCLES      = STORE_TIME_US * CLK_MHZ;
  // loader states, gray along the path
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_OFS  = 2'b01,
    LD_GAIN = 2'b11,
    LD_LOAD = 2'b10
  } scl_ld_state_t;
endpackage
`default_nettype wire

/* hdl/scl_store_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface scl_store_if;
  logic [8:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_req;
  logic [8:0] wr_addr;
  logic [7:0] wr_data;
  logic       busy;
  modport ctrl  (output rd_addr, output wr_req, output wr_addr, output wr_data,
                 input rd_data, input busy);
  modport store (input rd_addr, input wr_req, input wr_addr, input wr_data,
                 output rd_data, output busy);
endinterface
`default_nettype wire

/* hdl/scl_cal_store.sv */
`timescale 1ns/1ns
`default_nettype none
module scl_cal_store #(
  parameter int STORE_CYCLES = scl_pkg::STORE_CYCLES,
  parameter int DEPTH        = 512
) (
  input  wire logic   clk,
  input  wire logic   rst_b,
  scl_store_if.store  st
);
  logic [7:0]  mem [0:DEPTH-1];
  logic [16:0] cnt_ff;
  logic [7:0]  rd_data_ff;

  // byte write into the calibration array, ignored while a store runs
  always_ff @(posedge clk) begin
    if (st.wr_req && cnt_ff == 17'h0) begin
      mem[st.wr_addr] <= st.wr_data;
    end
  end

  // store time counter, busy for the whole store
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= 17'h0;
    end else if (st.wr_req && cnt_ff == 17'h0) begin
      cnt_ff <= 17'(STORE_CYCLES);
    end else if (cnt_ff != 17'h0) begin
      cnt_ff <= cnt_ff - 17'h1;
    end
  end

  // registered read port, one cycle latency
  always_ff @(posedge clk) begin
    rd_data_ff <= mem[st.rd_addr];
  end

  assign st.rd_data = rd_data_ff;
  assign st.busy    = (cnt_ff != 17'h0);
endmodule
`default_nettype wire

/* hdl/scl_loader.sv */
// The Wishbone register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module scl_loader #(
  parameter int STORE_CYCLES = scl_pkg::STORE_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic      [31:0] SE_SELECT,
  output logic      [15:0] DIFF_SELECT,
  output logic      [2:0]  RANGE_SEL,
  output logic      [7:0]  OFFSET_POT,
  output logic      [7:0]  GAIN_POT,
  output logic             POT_LOAD
);
  logic                      rst_meta_ff;
  logic                      rst_b_ff;
  logic                      ack_ff;
  logic [31:0]               dat_o_ff;
  logic [7:0]                cmd_ff;
  logic [7:0]                setup_ff;
  logic [8:0]                ee_addr_ff;
  logic [7:0]                ee_data_ff;
  logic                      ee_wr_ff;
  logic                      pend_ff;
  logic [4:0]                ld_ch_ff;
  logic [2:0]                ld_rng_ff;
  logic [8:0]                rd_addr_ff;
  logic [7:0]                ofs_ff;
  logic [7:0]                gain_ff;
  logic                      load_ff;
  logic [31:0]               se_sel_ff;
  logic [15:0]               diff_sel_ff;
  logic [2:0]                rng_out_ff;
  scl_pkg::scl_ld_state_t    state_ff;
  scl_pkg::scl_ld_state_t    nxt_state;
  logic                      req;
  logic                      wr_cmd;
  logic [7:0]                wr_byte;
  logic                      store_busy;
  logic [31:0]               rd_word;
  scl_store_if               st_if ();

  // eeprom address of a calibration byte for one input and range
  function automatic logic [8:0] ee_index(input logic region, input logic [2:0] rng,
                                          input logic [4:0] ch);
    ee_index = {region, rng, ch};
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta_ff <= 1'b0;
      rst_b_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_b_ff    <= rst_meta_ff;
    end
  end

  // wishbone request decode, one ack per access
  assign req     = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr_byte = WB_DAT_I[7:0];
  assign wr_cmd  = req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == scl_pkg::CMD_ADDR;

  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // read mux, unmapped addresses and the command register read zero
  always_comb begin
    rd_word = 32'h0;
    unique case (WB_ADR_I)
      scl_pkg::SETUP_ADDR: begin
        rd_word[7:0] = setup_ff;
        rd_word[scl_pkg::SETUP_BUSY_BIT] = store_busy;
      end
      scl_pkg::EE_ADDR_ADDR: rd_word[8:0] = ee_addr_ff;
      scl_pkg::EE_DATA_ADDR: rd_word[7:0] = ee_data_ff;
      scl_pkg::STATUS_ADDR: begin
        rd_word[scl_pkg::ST_OFS_LSB +: 8]  = ofs_ff;
        rd_word[scl_pkg::ST_GAIN_LSB +: 8] = gain_ff;
        rd_word[scl_pkg::ST_LOAD_BIT]      = pend_ff || state_ff != scl_pkg::LD_IDLE;
        rd_word[scl_pkg::ST_STORE_BIT]     = store_busy;
      end
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      dat_o_ff <= 32'h0;
    end else if (req && !WB_WE_I) begin
      dat_o_ff <= rd_word;
    end
  end

  // command register
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      cmd_ff <= scl_pkg::CMD_RST;
    end else if (wr_cmd) begin
      cmd_ff <= wr_byte;
    end
  end

  // setup register, bit 0 chooses single-ended routing
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      setup_ff <= scl_pkg::SETUP_RST;
    end else if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == scl_pkg::SETUP_ADDR) begin
      setup_ff <= wr_byte;
    end
  end

  // eeprom address register, byte lanes 0 and 1
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      ee_addr_ff <= 9'h0;
    end else if (req && WB_WE_I && WB_ADR_I == scl_pkg::EE_ADDR_ADDR) begin
      if (WB_SEL_I[0]) begin
        ee_addr_ff[7:0] <= WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        ee_addr_ff[8] <= WB_DAT_I[8];
      end
    end
  end

  // eeprom data write starts one store, dropped while busy
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      ee_data_ff <= 8'h0;
      ee_wr_ff   <= 1'b0;
    end else begin
      ee_wr_ff <= 1'b0;
      if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == scl_pkg::EE_DATA_ADDR
          && !store_busy && !ee_wr_ff) begin
        ee_data_ff <= wr_byte;
        ee_wr_ff   <= 1'b1;
      end
    end
  end

  assign st_if.wr_req  = ee_wr_ff;
  assign st_if.wr_addr = ee_addr_ff;
  assign st_if.wr_data = ee_data_ff;
  assign st_if.rd_addr = rd_addr_ff;
  assign store_busy    = st_if.busy || ee_wr_ff;

  // routing of the selected input follows each command write
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      se_sel_ff   <= 32'h0;
      diff_sel_ff <= 16'h0;
      rng_out_ff  <= scl_pkg::RNG_10V;
    end else if (wr_cmd) begin
      se_sel_ff   <= 32'h0;
      diff_sel_ff <= 16'h0;
      rng_out_ff  <= wr_byte[scl_pkg::RNG_MSB:scl_pkg::RNG_LSB];
      if (setup_ff[scl_pkg::SETUP_SE_BIT]) begin
        se_sel_ff[wr_byte[scl_pkg::CH_MSB:scl_pkg::CH_LSB]] <= 1'b1;
      end else begin
        diff_sel_ff[wr_byte[3:0]] <= 1'b1;
      end
    end
  end

  // pending reload, a new write wins over the clear
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      pend_ff <= 1'b0;
    end else if (wr_cmd) begin
      pend_ff <= 1'b1;
    end else if (state_ff == scl_pkg::LD_IDLE && !store_busy) begin
      pend_ff <= 1'b0;
    end
  end

  // loader sequence: offset read, gain read, pot load
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      scl_pkg::LD_IDLE: if (pend_ff && !store_busy) nxt_state = scl_pkg::LD_OFS;
      scl_pkg::LD_OFS:  nxt_state = scl_pkg::LD_GAIN;
      scl_pkg::LD_GAIN: nxt_state = scl_pkg::LD_LOAD;
      scl_pkg::LD_LOAD: nxt_state = scl_pkg::LD_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      state_ff <= scl_pkg::LD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // snapshot of the command being loaded
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      ld_ch_ff  <= 5'h0;
      ld_rng_ff <= 3'h0;
    end else if (state_ff == scl_pkg::LD_IDLE && pend_ff && !store_busy) begin
      ld_ch_ff  <= cmd_ff[scl_pkg::CH_MSB:scl_pkg::CH_LSB];
      ld_rng_ff <= cmd_ff[scl_pkg::RNG_MSB:scl_pkg::RNG_LSB];
    end
  end

  // eeprom read address for each step
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      rd_addr_ff <= 9'h0;
    end else if (state_ff == scl_pkg::LD_IDLE) begin
      rd_addr_ff <= ee_index(scl_pkg::EE_OFS_REGION,
                             cmd_ff[scl_pkg::RNG_MSB:scl_pkg::RNG_LSB],
                             cmd_ff[scl_pkg::CH_MSB:scl_pkg::CH_LSB]);
    end else if (state_ff == scl_pkg::LD_OFS) begin
      rd_addr_ff <= ee_index(scl_pkg::EE_GAIN_REGION, ld_rng_ff, ld_ch_ff);
    end
  end

  // pot values and one-cycle load strobe
  always_ff @(posedge MCLK or negedge rst_b_ff) begin
    if (!rst_b_ff) begin
      ofs_ff  <= scl_pkg::POT_RST;
      gain_ff <= scl_pkg::POT_RST;
      load_ff <= 1'b0;
    end else begin
      load_ff <= (state_ff == scl_pkg::LD_LOAD);
      if (state_ff == scl_pkg::LD_GAIN) begin
        ofs_ff <= st_if.rd_data;
      end
      if (state_ff == scl_pkg::LD_LOAD) begin
        gain_ff <= st_if.rd_data;
      end
    end
  end

  scl_cal_store #(
    .STORE_CYCLES (STORE_CYCLES),
    .DEPTH        (512)
  ) u_store (
    .clk   (MCLK),
    .rst_b (rst_b_ff),
    .st    (st_if.store)
  );

  assign WB_ACK_O    = ack_ff;
  assign WB_DAT_O    = dat_o_ff;
  assign SE_SELECT   = se_sel_ff;
  assign DIFF_SELECT = diff_sel_ff;
  assign RANGE_SEL   = rng_out_ff;
  assign OFFSET_POT  = ofs_ff;
  assign GAIN_POT    = gain_ff;
  assign POT_LOAD    = load_ff;
endmodule
`default_nettype wire

/* dv/scl_loader_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module scl_loader_sva #(
  parameter int STORE_CYCLES = 20
) (
  input wire logic        MCLK,
  input wire logic        RST_B,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic        WB_ACK_O,
  input wire logic [31:0] SE_SELECT,
  input wire logic [15:0] DIFF_SELECT,
  input wire logic [2:0]  RANGE_SEL,
  input wire logic [7:0]  GAIN_POT,
  input wire logic        POT_LOAD
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  logic        cmd_wr;
  logic [31:0] wait_ff;
  // command write taken on this edge
  assign cmd_wr = WB_CYC_I & WB_STB_I & WB_WE_I & WB_SEL_I[0] & !WB_ACK_O
                  & (WB_ADR_I == scl_pkg::CMD_ADDR);
  // cycles since the last command with no reload yet
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) wait_ff <= '0;
    else if (cmd_wr) wait_ff <= 32'h1;
    else if (POT_LOAD) wait_ff <= '0;
    else if (wait_ff != 0) wait_ff <= wait_ff + 32'h1;
  end
  ack_latency_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing one cycle after request");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  range_field_a: assert property (cmd_wr |=> RANGE_SEL == $past(WB_DAT_I[7:5]))
    else $error("range not from bits 7..5");
  route_field_a: assert property (cmd_wr |=>
    (SE_SELECT == (32'h1 << $past(WB_DAT_I[4:0])) && DIFF_SELECT == 16'h0)
    || (DIFF_SELECT == (16'h1 << $past(WB_DAT_I[3:0])) && SE_SELECT == 32'h0))
    else $error("route not from channel field");
  se_onehot_a: assert property ($onehot0(SE_SELECT))
    else $error("more than one input routed");
  diff_onehot_a: assert property ($onehot0(DIFF_SELECT))
    else $error("more than one pair routed");
  reload_due_a: assert property (wait_ff <= STORE_CYCLES + 12)
    else $error("pots not reloaded after command");
  gain_on_load_a: assert property ($changed(GAIN_POT) |-> POT_LOAD)
    else $error("gain pot changed outside a load");
  load_pulse_a: assert property (POT_LOAD |=> !POT_LOAD)
    else $error("load pulse too long");
  cover property (cmd_wr);
  cover property (cmd_wr && WB_DAT_I[7:5] == 3'h5);
  cover property (POT_LOAD);
endmodule
bind scl_loader scl_loader_sva #(.STORE_CYCLES(STORE_CYCLES)) u_sva (
  .MCLK(MCLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_ACK_O(WB_ACK_O),
  .SE_SELECT(SE_SELECT), .DIFF_SELECT(DIFF_SELECT), .RANGE_SEL(RANGE_SEL),
  .GAIN_POT(GAIN_POT), .POT_LOAD(POT_LOAD));
`default_nettype wire

/* dv/scl_host.sv */
`timescale 1ns/1ns
`default_nettype none
module scl_host (
  input  wire logic        MCLK,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic      [7:0]  adr,
  output logic      [3:0]  sel,
  output logic      [31:0] dat,
  output logic             hang
);
  // idle bus at time zero
  initial {cyc, stb, we, adr, sel, dat, hang} = '0;
  // one classic cycle, held until ack, read data taken at that edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    @(posedge MCLK);
    {cyc, stb} <= 2'b11;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (ack !== 1'b1 && n < 50);
    hang = (ack !== 1'b1);
    q = dat_i;
    {cyc, stb} <= 2'b00;
    dat <= ~d; // released data never repeats
  endtask
endmodule
`default_nettype wire

/* dv/test_scl_loader.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_scl_loader;
  logic        MCLK = 1'b0;
  logic        RST_B = 1'b0;
  logic        cyc, stb, we, hang, ack, pot_load;
  logic [7:0]  adr, ofs_pot, gain_pot, setup_v;
  logic [3:0]  sel;
  logic [31:0] dat_w, dat_r, q, se_sel;
  logic [15:0] diff_sel;
  logic [2:0]  rng_sel;
  logic [4:0]  ch;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          ee [512];
  int          a, n;
  always #10 MCLK = ~MCLK;
  scl_loader #(.STORE_CYCLES(20)) u_scl_loader (
    .MCLK(MCLK), .RST_B(RST_B), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
    .SE_SELECT(se_sel), .DIFF_SELECT(diff_sel), .RANGE_SEL(rng_sel),
    .OFFSET_POT(ofs_pot), .GAIN_POT(gain_pot), .POT_LOAD(pot_load));
  scl_host u_host (.MCLK(MCLK), .dat_i(dat_r), .ack(ack), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .dat(dat_w), .hang(hang));
  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // a hung bus ends the run
  always @(posedge hang) begin
    error_cnt++;
    tally_and_finish;
  end
  task automatic rd(input logic [7:0] ad);
    u_host.xfer(1'b0, ad, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    u_host.xfer(1'b1, ad, d, q);
  endtask
  // host polls busy before each store
  task automatic wait_idle;
    for (n = 0; n < 100; n++) begin
      rd(scl_pkg::SETUP_ADDR);
      if (q[scl_pkg::SETUP_BUSY_BIT] === 1'b0) break;
    end
    `CHK("setup", setup_v[6:0], q[6:0])
    if (n == 100) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic store(input int ad, input logic [7:0] v);
    wait_idle;
    wr(scl_pkg::EE_ADDR_ADDR, 32'(ad));
    wr(scl_pkg::EE_DATA_ADDR, {24'h0, v});
    ee[ad] = v;
    rd(scl_pkg::SETUP_ADDR);
    `CHK("busy", 1'b1, q[scl_pkg::SETUP_BUSY_BIT])
  endtask
  // routing at once, pots once the fetch lands
  task automatic command(input logic [2:0] r);
    a = r * 32 + ch;
    wr(scl_pkg::CMD_ADDR, {24'h0, r, ch});
    `CHK("range", r, rng_sel)
    if (setup_v[0]) `CHK("se route", {32'h1 << ch, 16'h0}, {se_sel, diff_sel})
    else `CHK("diff route", {32'h0, 16'h1 << ch[3:0]}, {se_sel, diff_sel})
    for (n = 0; n < 200 && pot_load !== 1'b1; n++) @(posedge MCLK);
    `CHK("reload", 1'b1, pot_load)
    if (pot_load !== 1'b1) tally_and_finish; // reload never came
    `CHK("offset pot", ee[a][7:0], ofs_pot)
    `CHK("gain pot", ee[a + 256][7:0], gain_pot)
    rd(scl_pkg::STATUS_ADDR);
    `CHK("status", {ee[a + 256][7:0], ee[a][7:0]}, q[15:0])
  endtask
  initial begin
    void'($urandom(45));
    setup_v = scl_pkg::SETUP_RST;
    repeat (20) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (4) @(posedge MCLK);
    `CHK("pot reset", {scl_pkg::POT_RST, scl_pkg::POT_RST}, {gain_pot, ofs_pot})
    rd(8'h14);
    `CHK("unmapped", 32'h0, q)
    rd(scl_pkg::CMD_ADDR);
    `CHK("cmd read", 32'h0, q)
    for (int r = 0; r < 6; r++) begin // ranges 000..101 only
      ch = (r == 0) ? scl_pkg::SINGLE_ENDED_INPUT_SIXTEEN : (r == 1) ? 5'h01 : 5'($urandom);
      setup_v = (r == 0 || (r > 1 && $urandom % 2)) ? 8'h11 : 8'h00;
      wr(scl_pkg::SETUP_ADDR, {24'h0, setup_v});
      store(r * 32 + ch, (r == 0) ? scl_pkg::EE_MID_SCALE : 8'($urandom));
      store(256 + r * 32 + ch, (r == 0) ? scl_pkg::EE_MID_SCALE : 8'($urandom));
      command(3'(r)); // reload waits for the store
    end
    // byte offered while a store runs is dropped
    store(511, 8'h5a);
    wr(scl_pkg::EE_DATA_ADDR, 32'ha5);
    rd(scl_pkg::EE_DATA_ADDR);
    `CHK("dropped store", 32'h5a, q)
    tally_and_finish;
  end
endmodule
`default_nettype wire
